// [rtl/asi_pkg.sv]
package asi_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ASI_SYS_CLR_OFS = 8'h14;
	localparam logic [7:0] ASI_SYS_IS_OFS = 8'h18;
	localparam logic [7:0] ASI_SUP_IS_OFS = 8'h1c;
	localparam logic [7:0] ASI_SUP_EN_OFS = 8'h20;
	localparam logic [7:0] ASI_SUP_CLR_OFS = 8'h24;
	localparam logic [7:0] ASI_SYS_EN_OFS = 8'h28;

	// ----------------------------------------
	// Reset values and full-word byte select
	// ----------------------------------------
	localparam logic [31:0] ASI_SUP_EN_RST = 32'h000000ff;
	localparam logic [31:0] ASI_SYS_EN_RST = 32'h00000000;
	localparam logic [3:0] ASI_FULL_WORD = 4'hf;

	// ----------------------------------------
	// Sizes and field positions
	// ----------------------------------------
	localparam int ASI_NSUP = 13;
	localparam int ASI_NIN = 29;
	localparam int ASI_NODES = 12;
	localparam int ASI_STS_LSB = 16;
	localparam int ASI_SUP_STS_SUM = 28;
	localparam int ASI_OT_STS = 25;
	localparam int ASI_OTW_STS = 24;
	localparam int ASI_TRX_FAIL_STS = 22;
	localparam int ASI_HS2_FAIL = 19;
	localparam int ASI_HS1_FAIL = 18;
	localparam int ASI_LS2_FAIL = 17;
	localparam int ASI_LS1_FAIL = 16;
	localparam int ASI_SUP_IS_SUM = 12;
	localparam int ASI_SYS_LAT_LSB = 8;
	localparam int ASI_TRX_FAIL_IS = 6;
	localparam int ASI_TRX_CLR_LSB = 4;

	// ----------------------------------------
	// Source vector positions
	// ----------------------------------------
	localparam int IN_UV = 0;
	localparam int IN_OV = 5;
	localparam int IN_PWR = 10;
	localparam int IN_REF_OV = 13;
	localparam int IN_REF_UV = 14;
	localparam int IN_OT = 15;
	localparam int IN_OTW = 16;
	localparam int IN_TRX_OC = 17;
	localparam int IN_TRX_OT = 18;
	localparam int IN_HS_OT = 19;
	localparam int IN_HS_OL = 21;
	localparam int IN_LS_OT = 23;
	localparam int IN_LS_WARN = 25;
	localparam int IN_LS_OL = 27;

endpackage

// [rtl/asi_top.sv]
`timescale 1ns/10ps
// Functional notes
// - Analog interrupts go out as twelve vector nodes plus the nmi line.
// - All supply interrupt sources merge into one supply prewarning nmi.
// - Power management output undervoltage, overvoltage, overcurrent join the supply sources.
// - All supply prewarning flags sit together in one supply status register.
// - Measurement flags latch on the rising edge of their condition.
// - Each latched supply flag has a live status twin bit.
// - Registers decode whole words; only full-word writes take effect.
// - Bit 28 is the read-only OR of all supply status flags.
// - Bit 12 is the read-only OR of all supply interrupt flags.
// - Bits 25 and 24 show overtemperature shutdown and prewarning state.
// - Bit 22 copies the transceiver overtemperature state.
// - Bits 19 and 18 are high-side overtemperature OR open-load.
// - Bits 17 and 16 are low-side overtemp, prewarning or open-load.
// - Bits 11 and 10 latch reference over and undervoltage.
// - Bit 9 latches the overtemperature shutdown edge.
// - Fail and summary flags read 1 when any source is set.
// - Writing 1 to a clear bit clears its flag; 0 leaves it.
// - Bit 6 is transceiver overcurrent OR overtemperature interrupt flag.
module asi_top
	import asi_pkg::*;
#(
	parameter int ADR_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Wishbone slave
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	// Supply monitors, index 0..4 = battery, supply, io rail, core rail, ext rail
	input wire logic [4:0] supply_under,
	input wire logic [4:0] supply_over,
	// Power management unit output checks: undervoltage, overvoltage, overcurrent
	input wire logic [2:0] power_management_unit_fault,
	// Eight-bit converter comparisons
	input wire logic reference_over,
	input wire logic reference_under,
	input wire logic overtemp_shutdown_in,
	input wire logic overtemp_warning_in,
	// Transceiver and driver states
	input wire logic transceiver_overcurrent,
	input wire logic transceiver_overtemp_state,
	input wire logic [1:0] highside_overtemp_state,
	input wire logic [1:0] highside_openload_state,
	input wire logic [1:0] lowside_overtemp_state,
	input wire logic [1:0] lowside_overtemp_warn_state,
	input wire logic [1:0] lowside_openload_state,
	// Interrupt outputs
	output logic supply_prewarn_nmi,
	output logic [ASI_NODES-1:0] analog_irq_node
);

	initial begin
		if (ADR_W < 6 || ADR_W > 32) begin
			$error("asi_top: ADR_W must lie in 6..32");
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
		hit = (adr == ADR_W'(ofs));
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Flags are fed from analog comparators on another timebase
	logic [ASI_NIN-1:0] raw_in;
	logic [ASI_NIN-1:0] sync1;
	logic [ASI_NIN-1:0] sync2;
	logic [ASI_NIN-1:0] sync3;
	logic [ASI_NIN-1:0] filt;
	wire [ASI_NIN-1:0] agree = ~(sync2 ^ sync3);
	wire [ASI_NIN-1:0] rise = agree & sync3 & ~filt;

	assign raw_in = {lowside_openload_state, lowside_overtemp_warn_state,
		lowside_overtemp_state, highside_openload_state, highside_overtemp_state,
		transceiver_overtemp_state, transceiver_overcurrent, overtemp_warning_in,
		overtemp_shutdown_in, reference_under, reference_over,
		power_management_unit_fault, supply_over, supply_under};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			filt <= '0;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= (agree & sync3) | (~agree & filt);
		end
	end

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic [ASI_NSUP-1:0] sup_is;
	logic [ASI_NSUP-1:0] sup_en;
	logic [3:0] sys_lat;
	logic [1:0] trx_is;
	logic [ASI_NODES-1:0] sys_en;

	wire req = wb_cyc_i & wb_stb_i;
	wire hit_sys_clr = hit(wb_adr_i, ASI_SYS_CLR_OFS);
	wire hit_sys_is = hit(wb_adr_i, ASI_SYS_IS_OFS);
	wire hit_sup_is = hit(wb_adr_i, ASI_SUP_IS_OFS);
	wire hit_sup_en = hit(wb_adr_i, ASI_SUP_EN_OFS);
	wire hit_sup_clr = hit(wb_adr_i, ASI_SUP_CLR_OFS);
	wire hit_sys_en = hit(wb_adr_i, ASI_SYS_EN_OFS);
	// Byte or halfword writes are dropped but still answered
	wire wr_ok = req & wb_we_i & wb_ack_o & (wb_sel_i == ASI_FULL_WORD);

	// ----------------------------------------
	// Flag updates
	// ----------------------------------------
	wire [ASI_NSUP-1:0] sup_clr = (wr_ok & hit_sup_clr) ? wb_dat_i[ASI_NSUP-1:0] : '0;
	wire [3:0] sys_clr = (wr_ok & hit_sys_clr) ? wb_dat_i[ASI_SYS_LAT_LSB +: 4] : '0;
	wire [1:0] trx_clr = (wr_ok & hit_sys_clr) ? wb_dat_i[ASI_TRX_CLR_LSB +: 2] : '0;
	wire [3:0] sys_rise = {rise[IN_REF_OV], rise[IN_REF_UV], rise[IN_OT], rise[IN_OTW]};
	// Set beats clear so a coincident event is never lost
	wire [ASI_NSUP-1:0] next_sup_is = (sup_is & ~sup_clr) | rise[ASI_NSUP-1:0];
	wire [3:0] next_sys_lat = (sys_lat & ~sys_clr) | sys_rise;
	wire [1:0] next_trx_is = (trx_is & ~trx_clr) | {rise[IN_TRX_OC], rise[IN_TRX_OT]};

	// ----------------------------------------
	// Read words
	// ----------------------------------------
	wire [ASI_NSUP-1:0] sup_sts = filt[ASI_NSUP-1:0];
	wire sum_sts = |sup_sts;
	wire sum_is = |sup_is;
	wire trx_fail_is = |trx_is;
	wire [1:0] hs_fail = filt[IN_HS_OT +: 2] | filt[IN_HS_OL +: 2];
	wire [1:0] ls_fail = filt[IN_LS_OT +: 2] | filt[IN_LS_WARN +: 2] | filt[IN_LS_OL +: 2];
	// Reserved fields are constant zero
	wire [31:0] sys_word = {3'h0, sum_sts, 2'h0, filt[IN_OT], filt[IN_OTW], 1'b0,
		filt[IN_TRX_OT], 2'h0, hs_fail, ls_fail, 3'h0, sum_is, sys_lat, 1'b0,
		trx_fail_is, 6'h00};
	wire [31:0] sup_word = {3'h0, sup_sts, 3'h0, sup_is};
	wire [31:0] rd_data = hit_sys_is ? sys_word :
		hit_sup_is ? sup_word :
		hit_sup_en ? {19'h0, sup_en} :
		hit_sys_en ? {20'h0, sys_en} : 32'h0;

	// ----------------------------------------
	// Interrupt outputs
	// ----------------------------------------
	wire next_nmi = |(sup_is & sup_en);
	// Node n carries system status bit n, gated by its enable
	wire [ASI_NODES-1:0] next_node = sys_word[ASI_NODES-1:0] & sys_en;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			wb_dat_o <= (req & ~wb_ack_o) ? rd_data : 32'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sup_is <= '0;
			sys_lat <= '0;
			trx_is <= '0;
		end else begin
			sup_is <= next_sup_is;
			sys_lat <= next_sys_lat;
			trx_is <= next_trx_is;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sup_en <= ASI_SUP_EN_RST[ASI_NSUP-1:0];
			sys_en <= ASI_SYS_EN_RST[ASI_NODES-1:0];
		end else begin
			if (wr_ok & hit_sup_en) begin
				sup_en <= wb_dat_i[ASI_NSUP-1:0];
			end
			if (wr_ok & hit_sys_en) begin
				sys_en <= wb_dat_i[ASI_NODES-1:0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			supply_prewarn_nmi <= 1'b0;
			analog_irq_node <= '0;
		end else begin
			supply_prewarn_nmi <= next_nmi;
			analog_irq_node <= next_node;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	wire rd_ack = wb_ack_o & req & ~wb_we_i;

	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	part_write_a: assert property (req && wb_we_i && wb_ack_o && wb_sel_i != ASI_FULL_WORD
		&& hit_sup_en |=> $stable(sup_en))
		else $error("partial write changed enable");
	edge_latch_a: assert property (agree[0] && sync3[0] && !filt[0] |=> sup_is[0])
		else $error("supply edge not latched");
	// A flag may be cleared one cycle later, so only the next cycle is checked
	flag_hold_a: assert property (sup_is[0] && !sup_clr[0] |=> sup_is[0])
		else $error("latched flag dropped without clear");
	clear_one_a: assert property (sup_clr[0] && !rise[0] |=> !sup_is[0])
		else $error("clear write ignored");
	nmi_follow_a: assert property (sup_is[3] && sup_en[3] |=> supply_prewarn_nmi)
		else $error("nmi missing for enabled flag");
	nmi_quiet_a: assert property (!(|(sup_is & sup_en)) |=> !supply_prewarn_nmi)
		else $error("nmi without source");
	sts_sum_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_SUP_STS_SUM] == $past(|filt[ASI_NSUP-1:0]))
		else $error("supply status summary wrong");
	is_sum_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_SUP_IS_SUM] == $past(|sup_is))
		else $error("supply interrupt summary wrong");
	ot_state_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_OT_STS] == $past(filt[IN_OT]))
		else $error("overtemperature state wrong");
	reserved_zero_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[31:29] == 3'h0 && wb_dat_o[27:26] == 2'h0 && !wb_dat_o[23]
		&& wb_dat_o[21:20] == 2'h0)
		else $error("reserved bits nonzero");
	sts_twin_a: assert property (rd_ack && hit_sup_is |->
		wb_dat_o[ASI_STS_LSB +: ASI_NSUP] == $past(filt[ASI_NSUP-1:0]))
		else $error("status twin mismatch");
	node_gate_a: assert property (sys_lat[1] && sys_en[9] |=> analog_irq_node[9])
		else $error("node not raised for enabled flag");
	node_quiet_a: assert property (!(|(sys_word[ASI_NODES-1:0] & sys_en)) |=>
		analog_irq_node == '0)
		else $error("node raised without enabled flag");

	// ----------------------------------------
	// Bus answer checks
	// ----------------------------------------
	ack_answer_a: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	sup_en_wr_a: assert property (wr_ok && hit_sup_en |=>
		sup_en == $past(wb_dat_i[ASI_NSUP-1:0]))
		else $error("supply enable write lost");
	sys_en_wr_a: assert property (wr_ok && hit_sys_en |=>
		sys_en == $past(wb_dat_i[ASI_NODES-1:0]))
		else $error("system enable write lost");
	part_clear_a: assert property (req && wb_we_i && wb_ack_o && wb_sel_i != ASI_FULL_WORD
		&& hit_sup_clr && sup_is[0] |=> sup_is[0])
		else $error("partial write cleared a flag");

	// ----------------------------------------
	// Latched flag checks
	// ----------------------------------------
	clear_race_a: assert property (sup_clr[0] && rise[0] |=> sup_is[0])
		else $error("coincident event lost to clear");
	ref_over_a: assert property (rise[IN_REF_OV] |=> sys_lat[3])
		else $error("reference over edge not latched");
	ref_under_a: assert property (rise[IN_REF_UV] |=> sys_lat[2])
		else $error("reference under edge not latched");
	ot_latch_a: assert property (rise[IN_OT] |=> sys_lat[1])
		else $error("overtemperature edge not latched");
	sys_hold_a: assert property (sys_lat[1] && !sys_clr[1] |=> sys_lat[1])
		else $error("system flag dropped without clear");
	sys_clear_a: assert property (sys_clr[1] && !rise[IN_OT] |=> !sys_lat[1])
		else $error("system clear ignored");
	trx_latch_a: assert property (rise[IN_TRX_OC] |=> trx_is[1])
		else $error("transceiver overcurrent edge not latched");
	trx_clear_a: assert property (trx_clr[1] && !rise[IN_TRX_OC] |=> !trx_is[1])
		else $error("transceiver clear ignored");

	// ----------------------------------------
	// Read word checks
	// ----------------------------------------
	otw_state_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_OTW_STS] == $past(filt[IN_OTW]))
		else $error("overtemperature warning state wrong");
	trx_state_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_TRX_FAIL_STS] == $past(filt[IN_TRX_OT]))
		else $error("transceiver fail state wrong");
	hs_two_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_HS2_FAIL] == $past(filt[IN_HS_OT+1] | filt[IN_HS_OL+1]))
		else $error("high-side two fail wrong");
	hs_one_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_HS1_FAIL] == $past(filt[IN_HS_OT] | filt[IN_HS_OL]))
		else $error("high-side one fail wrong");
	ls_two_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_LS2_FAIL] == $past(filt[IN_LS_OT+1] | filt[IN_LS_WARN+1] | filt[IN_LS_OL+1]))
		else $error("low-side two fail wrong");
	ls_one_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_LS1_FAIL] == $past(filt[IN_LS_OT] | filt[IN_LS_WARN] | filt[IN_LS_OL]))
		else $error("low-side one fail wrong");
	trx_fail_a: assert property (rd_ack && hit_sys_is |->
		wb_dat_o[ASI_TRX_FAIL_IS] == $past(|trx_is))
		else $error("transceiver fail flag wrong");
	sup_rsv_a: assert property (rd_ack && hit_sup_is |->
		wb_dat_o[31:29] == 3'h0 && wb_dat_o[15:13] == 3'h0)
		else $error("supply reserved bits nonzero");

	nmi_rise_c: cover property ($rose(supply_prewarn_nmi));
	clear_race_c: cover property (sup_clr[0] && rise[0]);
	sys_read_c: cover property (rd_ack && hit_sys_is && wb_dat_o[ASI_TRX_FAIL_IS]);
	node_fall_c: cover property ($fell(analog_irq_node[8]));
	trx_clear_c: cover property (trx_clr[1] && trx_is[1]);

endmodule // asi_top

// [dv/asi_src_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Analog monitor sources
// ----------------------------------------
module asi_src_model
	import asi_pkg::*;
(
	// Requested levels
	input wire logic [ASI_NIN-1:0] src,
	// Source pins
	output logic [4:0] s_under,
	output logic [4:0] s_over,
	output logic [2:0] power_management_unit,
	output logic [3:0] adc,
	output logic [1:0] trx,
	output logic [1:0] hs_ot,
	output logic [1:0] hs_ol,
	output logic [1:0] ls_ot,
	output logic [1:0] ls_warn,
	output logic [1:0] ls_ol
);
	// Plain levels only; the unit filters them itself
	assign s_under = src[IN_UV +: 5];
	assign s_over = src[IN_OV +: 5];
	assign power_management_unit = src[IN_PWR +: 3];
	assign adc = src[IN_REF_OV +: 4];
	assign trx = src[IN_TRX_OC +: 2];
	assign hs_ot = src[IN_HS_OT +: 2];
	assign hs_ol = src[IN_HS_OL +: 2];
	assign ls_ot = src[IN_LS_OT +: 2];
	assign ls_warn = src[IN_LS_WARN +: 2];
	assign ls_ol = src[IN_LS_OL +: 2];
endmodule // asi_src_model

// [dv/analog_supply_interrupt_unit_tb.sv]
`timescale 1ns/10ps
module analog_supply_interrupt_unit_tb
	import asi_pkg::*;
;
	logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dati = 32'h0, rd, seed = 32'h77df, e;
	logic [3:0] sel = 4'h0;
	logic [ASI_NIN-1:0] src = '0, s;
	logic [12:0] en, m;
	logic [4:0] su, so;
	logic [2:0] power_management_unit;
	logic [3:0] adc;
	logic [1:0] trx, hot, hol, lot, lwr, lol;
	logic [31:0] dato;
	logic ack, nmi;
	logic [11:0] node;
	int fails = 0, checks_done = 0, cyc_cnt = 0;
	always #2.5 clk = ~clk;
	asi_src_model i_src (.src(src), .s_under(su), .s_over(so), .power_management_unit(power_management_unit), .adc(adc), .trx(trx),
		.hs_ot(hot), .hs_ol(hol), .ls_ot(lot), .ls_warn(lwr), .ls_ol(lol));
	asi_top i_dut (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dati), .wb_dat_o(dato),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
		.supply_under(su), .supply_over(so), .power_management_unit_fault(power_management_unit),
		.reference_over(adc[0]), .reference_under(adc[1]), .overtemp_shutdown_in(adc[2]),
		.overtemp_warning_in(adc[3]), .transceiver_overcurrent(trx[0]),
		.transceiver_overtemp_state(trx[1]), .highside_overtemp_state(hot),
		.highside_openload_state(hol), .lowside_overtemp_state(lot),
		.lowside_overtemp_warn_state(lwr), .lowside_openload_state(lol),
		.supply_prewarn_nmi(nmi), .analog_irq_node(node));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Expected system status after rising edges from an all-clear state
	function automatic logic [31:0] exp_sys(input logic [ASI_NIN-1:0] v);
		logic [31:0] r;
		r = 32'h0;
		r[28] = |v[12:0];
		r[25] = v[IN_OT];
		r[24] = v[IN_OTW];
		r[22] = v[IN_TRX_OT];
		r[19] = v[IN_HS_OT+1] | v[IN_HS_OL+1];
		r[18] = v[IN_HS_OT] | v[IN_HS_OL];
		r[17] = v[IN_LS_OT+1] | v[IN_LS_WARN+1] | v[IN_LS_OL+1];
		r[16] = v[IN_LS_OT] | v[IN_LS_WARN] | v[IN_LS_OL];
		r[12] = |v[12:0];
		r[11] = v[IN_REF_OV];
		r[10] = v[IN_REF_UV];
		r[9] = v[IN_OT];
		r[8] = v[IN_OTW];
		r[6] = v[IN_TRX_OC] | v[IN_TRX_OT];
		return r;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Classic single cycle; waits for ack with no assumed latency
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] bs, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		we <= w;
		dati <= d;
		sel <= bs;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		q = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Run is about 2200 cycles; ceiling leaves wide margin
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		bus(ASI_SUP_EN_OFS, 0, 0, 4'hf, rd); chk("sup_en", rd, ASI_SUP_EN_RST);
		bus(ASI_SYS_EN_OFS, 0, 0, 4'hf, rd); chk("sys_en", rd, ASI_SYS_EN_RST);
		bus(ASI_SYS_IS_OFS, 0, 0, 4'hf, rd); chk("sys_is", rd, 32'h0);
		bus(8'h30, 0, 0, 4'hf, rd); chk("unmapped", rd, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			@(posedge clk) src <= '0;
			repeat (8) @(posedge clk);
			bus(ASI_SYS_CLR_OFS, 1, 32'hffffffff, 4'hf, rd);
			bus(ASI_SUP_CLR_OFS, 1, 32'hffffffff, 4'hf, rd);
			seed = xs(seed);
			s = (i == 0) ? '1 : seed[ASI_NIN-1:0];
			@(posedge clk) src <= s;
			repeat (8) @(posedge clk);
			// Read-only status must ignore this write
			bus(ASI_SYS_IS_OFS, 1, 32'hffffffff, 4'hf, rd);
			e = exp_sys(s);
			bus(ASI_SYS_IS_OFS, 0, 0, 4'hf, rd); chk("sys_is", rd, e);
			bus(ASI_SUP_IS_OFS, 0, 0, 4'hf, rd); chk("sup_is", rd, {3'b0, s[12:0], 3'b0, s[12:0]});
			seed = xs(seed);
			en = seed[12:0];
			bus(ASI_SUP_EN_OFS, 1, {19'h0, en}, 4'hf, rd);
			bus(ASI_SYS_EN_OFS, 1, {20'h0, seed[27:16]}, 4'hf, rd);
			repeat (3) @(posedge clk);
			chk("nmi", {31'h0, nmi}, {31'h0, |(s[12:0] & en)});
			chk("node", {20'h0, node}, {20'h0, e[11:0] & seed[27:16]});
			bus(ASI_SUP_EN_OFS, 0, 0, 4'hf, rd); chk("sup_en", rd, {19'h0, en});
			// Partial byte lanes must not clear anything
			bus(ASI_SUP_CLR_OFS, 1, 32'hffffffff, 4'h7, rd);
			seed = xs(seed);
			m = seed[12:0];
			bus(ASI_SUP_CLR_OFS, 1, {19'h0, m}, 4'hf, rd);
			bus(ASI_SUP_IS_OFS, 0, 0, 4'hf, rd); chk("sup_clr", rd, {3'b0, s[12:0], 3'b0, s[12:0] & ~m});
		end
		$display("test random sources done");
		give_verdict();
	end
endmodule // analog_supply_interrupt_unit_tb
